// ==== mic_pkg.sv ====
package mic_pkg;
  localparam logic [7:0] MIC_ADDR_CTRL   = 8'h0B;
  localparam logic [7:0] MIC_ADDR_PFLAG  = 8'h0C;
  localparam logic [7:0] MIC_ADDR_PEN    = 8'h8C;
  localparam logic [7:0] MIC_ADDR_ISTAT  = 8'hF0;
  localparam logic [7:0] MIC_ADDR_IMASK  = 8'hF1;
  localparam logic [7:0] MIC_ADDR_OPTION = 8'h81;
  localparam logic [12:0] MIC_VECTOR     = 13'h0004;
  localparam logic [7:0] MIC_TMR_MAX     = 8'hFF;
  localparam logic [7:0] MIC_TMR_ZERO    = 8'h00;
  localparam logic [7:0] MIC_PFLAG_IMPL  = 8'hF7;
  localparam logic [7:0] MIC_OPTION_RST  = 8'hFF;
  localparam logic [7:0] MIC_ZERO8       = 8'h00;
  localparam int MIC_B_GIE  = 7;
  localparam int MIC_B_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int MIC_B_TIMER0_OVERFLOW_ENABLE = 5;
  localparam int MIC_B_EXIE = 4;
  localparam int MIC_B_PCIE = 3;
  localparam int MIC_B_T0F  = 2;
  localparam int MIC_B_EXF  = 1;
  localparam int MIC_B_PCF  = 0;
  localparam int MIC_B_EDGE = 6;
  localparam int MIC_LATENCY_TCY = 3;

  typedef enum logic [3:0] {
    MIC_Q1 = 4'b0001,
    MIC_Q2 = 4'b0010,
    MIC_Q3 = 4'b0100,
    MIC_Q4 = 4'b1000
  } mic_phase_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mic_bus_s;

  typedef struct packed {
    logic        take;
    logic [12:0] vector;
    logic        push_pc;
  } mic_vec_s;
endpackage

// ==== mic_irq_ctrl.sv ====
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - global enable bit 7 passes unmasked sources; clear blocks all requests.
// - reset clears the global enable.
// - return instruction sets the global enable again.
// - taking an interrupt clears global enable, pushes pc, vectors to 0004h.
// - flags set on their event regardless of any enable.
// - latency three cycles from flag, independent of instruction length.
// - clearing global enable cancels next-cycle interrupt; nop; request stays pending.
// - external pin edge polarity follows option bit 6.
// - valid external edge sets bit 1; bit 4 enables it.
// - enabled external pin wakes from sleep; global enable decides vectoring.
// - timer zero rollover from ffh sets bit 2; bit 5 enables it.
// - upper port nibble change sets bit 0; bit 3 enables it.
// - port change during a q2 port read may be missed.
// - external flag sampled each q1, settable during q4 to q1; here an edge sets it in any phase.
// - peripheral flags and enables in separate registers, fixed bit order.
// - only the return pc is saved on entry.
module mic_irq_ctrl #(
  parameter int LATENCY = mic_pkg::MIC_LATENCY_TCY
) (
  input  wire logic                  CLK,
  input  wire logic                  SYS_RST,
  input  wire mic_pkg::mic_bus_s     BUS,
  input  wire logic                  EXT_IRQ_PIN,
  input  wire logic [7:0]            TIMER_ZERO_COUNT,
  input  wire logic [3:0]            PORT_HI_PINS,
  input  wire logic                  PORT_READ,
  input  wire logic [7:0]            PERIPH_EVENTS,
  input  wire logic                  RETURN_FROM_IRQ_INSTR,
  input  wire logic                  SLEEPING,
  output logic [7:0]                 RDATA,
  output mic_pkg::mic_vec_s          VEC,
  output logic                       WAKE,
  output logic                       NOP_SLOT,
  output logic                       IRQ
);
  import mic_pkg::*;

  mic_phase_e phase_r;
  logic [7:0] ctrl_r;
  logic [7:0] pflag_r;
  logic [7:0] pen_r;
  logic [7:0] option_r;
  logic [7:0] istat_r;
  logic [7:0] imask_r;
  logic       pin_d_r;
  logic [7:0] tmr_d_r;
  logic [3:0] port_d_r;
  logic [LATENCY-1:0] pipe_r;
  logic       wr_ctrl;
  logic       wr_pflag;
  logic       ext_edge;
  logic       tmr_roll;
  logic       port_chg;
  logic       core_match;
  logic       per_match;
  logic       request;
  logic       gie_clear_wr;
  logic       take;
  logic [7:0] ctrl_nxt;
  logic [7:0] pflag_nxt;
  logic [7:0] events;

  assign wr_ctrl  = BUS.wr && BUS.addr == MIC_ADDR_CTRL;
  assign wr_pflag = BUS.wr && BUS.addr == MIC_ADDR_PFLAG;
  // edge polarity chosen by option bit
  assign ext_edge = option_r[MIC_B_EDGE] ? (EXT_IRQ_PIN && !pin_d_r)
                                         : (!EXT_IRQ_PIN && pin_d_r);
  assign tmr_roll = tmr_d_r == MIC_TMR_MAX && TIMER_ZERO_COUNT == MIC_TMR_ZERO;
  // a change landing while the port is read in q2 is dropped, as on the real part
  assign port_chg = (PORT_HI_PINS != port_d_r) && !(PORT_READ && phase_r == MIC_Q2);
  assign core_match = |(ctrl_r[MIC_B_TIMER0_OVERFLOW_ENABLE:MIC_B_PCIE] & ctrl_r[MIC_B_T0F:MIC_B_PCF]);
  assign per_match  = ctrl_r[MIC_B_PERIPHERAL_IRQ_ENABLE] && |(pflag_r & pen_r);
  assign request    = ctrl_r[MIC_B_GIE] && (core_match || per_match);
  assign gie_clear_wr = wr_ctrl && !BUS.wdata[MIC_B_GIE];
  // pipeline advances each q1 only, so instruction length never changes latency
  assign take = pipe_r[LATENCY-1] && phase_r == MIC_Q1 && request && !gie_clear_wr;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      phase_r <= MIC_Q1;
    end else begin
      case (phase_r)
        MIC_Q1:  phase_r <= MIC_Q2;
        MIC_Q2:  phase_r <= MIC_Q3;
        MIC_Q3:  phase_r <= MIC_Q4;
        MIC_Q4:  phase_r <= MIC_Q1;
        default: phase_r <= MIC_Q1;
      endcase
    end
  end

  // history tracks the inputs through reset too, so a pin resting high gives no false edge after release
  always_ff @(posedge CLK) begin
    pin_d_r  <= EXT_IRQ_PIN;
    tmr_d_r  <= TIMER_ZERO_COUNT;
    port_d_r <= PORT_HI_PINS;
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = BUS.wdata;
    end
    if (RETURN_FROM_IRQ_INSTR) begin
      ctrl_nxt[MIC_B_GIE] = 1'b1;
    end
    if (take) begin
      ctrl_nxt[MIC_B_GIE] = 1'b0;
    end
    // hardware set wins over a software clear; flags ignore enables
    if (ext_edge) begin
      ctrl_nxt[MIC_B_EXF] = 1'b1;
    end
    if (tmr_roll) begin
      ctrl_nxt[MIC_B_T0F] = 1'b1;
    end
    if (port_chg) begin
      ctrl_nxt[MIC_B_PCF] = 1'b1;
    end
  end

  always_comb begin
    pflag_nxt = pflag_r;
    if (wr_pflag) begin
      pflag_nxt = BUS.wdata;
    end
    pflag_nxt = (pflag_nxt | PERIPH_EVENTS) & MIC_PFLAG_IMPL;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_r  <= MIC_ZERO8;
      pflag_r <= MIC_ZERO8;
    end else begin
      ctrl_r  <= ctrl_nxt;
      pflag_r <= pflag_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pen_r    <= MIC_ZERO8;
      option_r <= MIC_OPTION_RST;
      imask_r  <= MIC_ZERO8;
    end else if (BUS.wr) begin
      if (BUS.addr == MIC_ADDR_PEN) begin
        pen_r <= BUS.wdata & MIC_PFLAG_IMPL;
      end
      if (BUS.addr == MIC_ADDR_OPTION) begin
        option_r <= BUS.wdata;
      end
      if (BUS.addr == MIC_ADDR_IMASK) begin
        imask_r <= BUS.wdata;
      end
    end
  end

  // latency pipe: the request must persist LATENCY instruction cycles before vectoring
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pipe_r <= '0;
    end else if (!request) begin
      pipe_r <= '0; // ignored request re-arms when gie returns
    end else if (phase_r == MIC_Q1 && !take) begin
      pipe_r <= {pipe_r[LATENCY-2:0], 1'b1};
    end else if (take) begin
      pipe_r <= '0;
    end
  end

  // status events: bit0 vector taken, bit1 wake, bit2 nop slot
  always_comb begin
    events = MIC_ZERO8;
    events[0] = take;
    events[1] = SLEEPING && ctrl_r[MIC_B_EXIE] && ext_edge;
    events[2] = gie_clear_wr && pipe_r[LATENCY-1] && request;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      istat_r <= MIC_ZERO8;
    end else if (BUS.rd && BUS.addr == MIC_ADDR_ISTAT) begin
      istat_r <= events;
    end else begin
      istat_r <= istat_r | events;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA <= MIC_ZERO8;
    end else if (BUS.rd) begin
      case (BUS.addr)
        MIC_ADDR_CTRL:   RDATA <= ctrl_r;
        MIC_ADDR_PFLAG:  RDATA <= pflag_r;
        MIC_ADDR_PEN:    RDATA <= pen_r;
        MIC_ADDR_OPTION: RDATA <= option_r;
        MIC_ADDR_ISTAT:  RDATA <= istat_r;
        MIC_ADDR_IMASK:  RDATA <= imask_r;
        default:         RDATA <= MIC_ZERO8;
      endcase
    end else begin
      RDATA <= MIC_ZERO8;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      VEC      <= '0;
      WAKE     <= 1'b0;
      NOP_SLOT <= 1'b0;
      IRQ      <= 1'b0;
    end else begin
      VEC.take    <= take;
      VEC.vector  <= MIC_VECTOR;
      VEC.push_pc <= take; // only the pc is pushed
      // wake on enabled, set external flag regardless of gie
      WAKE     <= SLEEPING && ctrl_nxt[MIC_B_EXIE] && ctrl_nxt[MIC_B_EXF];
      NOP_SLOT <= gie_clear_wr;
      IRQ      <= |(istat_r & imask_r);
    end
  end
endmodule

// ==== mic_irq_ctrl_asserts.sv ====
`timescale 1ns/1ps
module mic_irq_ctrl_asserts #(
  parameter int LATENCY = 3
) (
  input wire logic              CLK,
  input wire logic              SYS_RST,
  input wire mic_pkg::mic_bus_s BUS,
  input wire logic              SLEEPING,
  input wire logic [7:0]        RDATA,
  input wire mic_pkg::mic_vec_s VEC,
  input wire logic              WAKE,
  input wire logic              NOP_SLOT,
  input wire logic              IRQ
);
  import mic_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_rdata_idle: assert property (
    !$past(BUS.rd) |-> RDATA == MIC_ZERO8) else $error("stray read data");
  a_pflag_gap: assert property (
    $past(BUS.rd) && $past(BUS.addr[6:0]) == 7'h0C |-> !RDATA[3]) else $error("unused flag bit set");
  a_vector_addr: assert property (
    VEC.take |-> VEC.vector == MIC_VECTOR && VEC.push_pc) else $error("bad vector");
  a_take_single: assert property (
    VEC.take |=> !VEC.take) else $error("take too long");
  a_nop_cause: assert property (
    NOP_SLOT |-> $past(BUS.wr && BUS.addr == MIC_ADDR_CTRL && !BUS.wdata[MIC_B_GIE])) else $error("stray nop");
  a_nop_pulse: assert property (
    NOP_SLOT |=> !NOP_SLOT) else $error("nop too long");
  a_wake_sleep: assert property (
    !$past(SLEEPING) |-> !WAKE) else $error("wake while awake");
  a_reset_quiet: assert property (
    disable iff (1'b0) $fell(SYS_RST) |-> !VEC.take && !IRQ && !WAKE) else $error("busy after reset");
endmodule
bind mic_irq_ctrl mic_irq_ctrl_asserts #(.LATENCY(LATENCY)) i_mic_irq_ctrl_asserts (
  .CLK(CLK), .SYS_RST(SYS_RST), .BUS(BUS), .SLEEPING(SLEEPING), .RDATA(RDATA),
  .VEC(VEC), .WAKE(WAKE), .NOP_SLOT(NOP_SLOT), .IRQ(IRQ));

// ==== mic_periph_model.sv ====
`timescale 1ns/1ps
module mic_periph_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  output logic [7:0]      count
);
  // held still unless asked, else overflow flags would pollute every read
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 8'h00;
    end else if (run) begin
      count <= count + 8'h01;
    end
  end
endmodule

// ==== mcu_interrupt_controller_tb_top.sv ====
`timescale 1ns/1ps
module mcu_interrupt_controller_tb_top;
  import mic_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, pin = 1'b0, ret = 1'b0, slp = 1'b0, run = 1'b0;
  logic       wake, nop, irq;
  logic       prd = 1'b0;
  int         ph = 0;
  logic [3:0] port = 4'h0;
  logic [7:0] pev = 8'h00, tmr, q, rdata;
  mic_bus_s   bus = '0;
  mic_vec_s   vec;
  int         num_errors = 0, comparisons = 0, seed = 25482, n;
  always #12.5 clk = ~clk;
  // mirror of the four-phase ring: 0 is q1, 1 is q2
  always @(posedge clk) ph <= rst ? 0 : (ph + 1) % 4;
  mic_irq_ctrl #(.LATENCY(MIC_LATENCY_TCY)) i_mic_irq_ctrl (.CLK(clk), .SYS_RST(rst), .BUS(bus),
    .EXT_IRQ_PIN(pin), .TIMER_ZERO_COUNT(tmr), .PORT_HI_PINS(port), .PORT_READ(prd), .PERIPH_EVENTS(pev),
    .RETURN_FROM_IRQ_INSTR(ret), .SLEEPING(slp), .RDATA(rdata), .VEC(vec), .WAKE(wake), .NOP_SLOT(nop), .IRQ(irq));
  mic_periph_model i_mic_periph_model (.clk(clk), .rst(rst), .run(run), .count(tmr));
  task automatic chk(input logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask
  // idle edges first so flags raised just before the read have landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    repeat (3) @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    @(negedge clk) d = rdata;
  endtask
  task automatic rc(input logic [7:0] a, e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic wt(output int k);
    for (k = 0; k < 40; k++) begin
      @(negedge clk);
      if (vec.take === 1'b1) break;
    end
  endtask
  task automatic pulse_ret;
    @(posedge clk) ret <= 1'b1;
    @(posedge clk) ret <= 1'b0;
  endtask
  task end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rc(MIC_ADDR_CTRL, MIC_ZERO8);
    rc(MIC_ADDR_OPTION, MIC_OPTION_RST);
    @(posedge clk) pin <= 1'b1;
    rc(MIC_ADDR_CTRL, 8'h02);
    wr(MIC_ADDR_CTRL, MIC_ZERO8);
    wr(MIC_ADDR_OPTION, 8'hBF);
    @(posedge clk) pin <= 1'b0;
    rc(MIC_ADDR_CTRL, 8'h02);
    wr(MIC_ADDR_CTRL, MIC_ZERO8);
    @(posedge clk) pin <= 1'b1;
    rc(MIC_ADDR_CTRL, MIC_ZERO8);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) port <= port ^ (4'($random(seed)) | 4'h1);
      rc(MIC_ADDR_CTRL, 8'h01);
      wr(MIC_ADDR_CTRL, MIC_ZERO8);
    end
    // port change under a port read: only the change landing in q2 is lost
    for (int i = 0; i < 4; i++) begin
      do @(negedge clk); while (ph != i);
      @(posedge clk) begin
        prd  <= 1'b1;
        port <= port ^ 4'h2;
      end
      @(posedge clk) prd <= 1'b0;
      rc(MIC_ADDR_CTRL, (i == 0) ? MIC_ZERO8 : 8'h01);
      wr(MIC_ADDR_CTRL, MIC_ZERO8);
    end
    @(posedge clk) run <= 1'b1;
    repeat (260) @(posedge clk);
    run <= 1'b0;
    rc(MIC_ADDR_CTRL, 8'h04);
    q = 8'($random(seed));
    @(posedge clk) pev <= q;
    @(posedge clk) pev <= 8'h00;
    rc(MIC_ADDR_PFLAG, q & MIC_PFLAG_IMPL);
    wr(MIC_ADDR_PEN, q);
    rc(MIC_ADDR_PEN, q & MIC_PFLAG_IMPL);
    wr(MIC_ADDR_PFLAG, MIC_ZERO8);
    wr(MIC_ADDR_IMASK, 8'h01);
    rd(MIC_ADDR_ISTAT, q);
    wr(MIC_ADDR_CTRL, 8'hA4);
    wt(n);
    chk(8'(n > 9 && n < 21), 8'h01);
    rc(MIC_ADDR_CTRL, 8'h24);
    chk(8'(irq), 8'h01);
    rd(MIC_ADDR_ISTAT, q);
    chk(q & 8'h01, 8'h01);
    @(negedge clk) chk(8'(irq), MIC_ZERO8);
    wr(MIC_ADDR_CTRL, 8'h20);
    pulse_ret;
    rc(MIC_ADDR_CTRL, 8'hA0);
    do @(negedge clk); while (ph != 3);
    wr(MIC_ADDR_CTRL, 8'hA4);
    // clear the global enable in the very q1 slot in which the vector would be taken
    repeat (14) @(posedge clk);
    wr(MIC_ADDR_CTRL, 8'h24);
    @(negedge clk) chk(8'(nop), 8'h01);
    wt(n);
    chk(8'(n), 8'd40);
    rd(MIC_ADDR_ISTAT, q);
    chk(q, 8'h04);
    pulse_ret;
    wt(n);
    chk(8'(n < 40), 8'h01);
    wr(MIC_ADDR_CTRL, 8'h12);
    @(posedge clk) slp <= 1'b1;
    repeat (3) @(negedge clk);
    chk(8'(wake), 8'h01);
    @(posedge clk) slp <= 1'b0;
    pulse_ret;
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(MIC_ADDR_CTRL, MIC_ZERO8);
    rc(MIC_ADDR_OPTION, MIC_OPTION_RST);
    end_of_test;
  end
endmodule
